/* File: inc/asp_defines.vh */
// asp_defines.vh: offsets, mode codes and timing counts for the serial ports
// assumes: included by its bare name from the design files
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
`define ASP_MODE_LJ 2'h0
`define ASP_MODE_LJ_DLY 2'h1
`define ASP_MODE_RJ 2'h2
`define ASP_MODE_WORD 2'h3
`define ASP_RJ_DELAY 16
`define ASP_IN_MIN_BITS 4
`define ASP_IN_MAX_BITS 16
`define ASP_OUT_MAX_BITS 24
`define ASP_MUTE_MIN_CYCLES 128
`define ASP_CLK_HZ 50000000
`define ASP_FAST_SETTLE_MS 200
`define ASP_SLOW_SETTLE_MS 800
`define ASP_FAST_SETTLE_CYC ((`ASP_CLK_HZ / 1000) * `ASP_FAST_SETTLE_MS)
`define ASP_SLOW_SETTLE_CYC ((`ASP_CLK_HZ / 1000) * `ASP_SLOW_SETTLE_MS)
`endif

/* File: design/asp_sync.v */
// asp_sync.v: two-flop synchroniser for a bus of asynchronous levels
// assumes: inputs come from pins or another clock domain
`timescale 1ns/1ps
module asp_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire sysClk,
  input wire resetN,
  // levels
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always @(posedge sysClk)
  begin
    if (!resetN)
    begin
      stage1 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

/* File: design/asp_buf2.v */
// asp_buf2.v: two-entry buffer with valid/ready on both sides
// assumes: single clock, registered read data
`timescale 1ns/1ps
module asp_buf2 #(
  parameter WIDTH = 32,
  parameter DEPTH = 2
) (
  // clock and reset
  input wire sysClk,
  input wire resetN,
  // filling side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // draining side
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [1:0] count;
  reg wrPtr;
  reg rdPtr;
  wire push;
  wire pop;
  wire memHas;

  // outData is a register, so one entry may sit in it and one in memory
  assign inReady = (count < DEPTH[1:0]);
  assign push = inValid && inReady;
  assign memHas = (count != 2'h0) && !(outValid && count == 2'h1);
  assign pop = (!outValid || outReady) && memHas;

  always @(posedge sysClk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  // pointers, count and registered head
  always @(posedge sysClk)
  begin
    if (!resetN)
    begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wrPtr <= ~wrPtr;
      if (pop)
      begin
        rdPtr <= ~rdPtr;
        outData <= mem[rdPtr];
        outValid <= 1'b1;
      end
      else if (outReady)
        outValid <= 1'b0;
      case ({push, outValid && outReady})
        2'b10: count <= count + 2'h1;
        2'b01: count <= count - 2'h1;
        default: count <= count;
      endcase
    end
  end
endmodule

/* File: design/asp_ports.v */
// asp_ports.v: stereo serial input and output ports with mute control
// assumes: all port clocks and pins are asynchronous and sampled by sysClk,
// which must run well above twice the fastest bit clock
// How it works
// RQ1: source keeps frame clocks continuous, two toggles
// RQ2: bit and word clocks may arrive gated
// RQ3: input frame clock sampled by bit clock
// RQ4: two's complement words, MSB first
// RQ5: left word first, frame level names channel
// RQ6: input 4..16 bits, output 4..24 read
// RQ7: polarity pin picks rising or falling edge
// RQ8: two mode pins select framing
// RQ9: word clock mode starts at word rise
// RQ10: left on frame rise, right on fall
// RQ11: delayed mode starts one bit later
// RQ12: right justified starts 16 bits later
// RQ13: word clock ignored in frame modes
// RQ14: bit clock may idle high or low
// RQ15: no gap needed between channels
// RQ16: frame clock duty cycle is free
// RQ17: sleep request halts all activity
// RQ18: control pins stable before first MSB
// RQ19: reset gives 1:1, mute 128 cycles
// RQ20: mute held while rate loop settles; code mutes only in first 256 window cycles, while periods differ
// RQ21: system waits for mute low
// RQ22: unreset settle 200 or 800 ms
// RQ23: mute when buffer pointers cross
// RQ24: control pins synchronised before use
`timescale 1ns/1ps
`include "asp_defines.vh"
module asp_ports #(
  parameter FAST_SETTLE = `ASP_FAST_SETTLE_CYC,
  parameter SLOW_SETTLE = `ASP_SLOW_SETTLE_CYC,
  parameter MUTE_MIN = `ASP_MUTE_MIN_CYCLES,
  parameter OUT_BITS = `ASP_OUT_MAX_BITS
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // input serial port pins
  input wire inBitClock,
  input wire inWordClock,
  input wire in_frame_clock,
  input wire inData,
  // output serial port pins
  input wire outBitClock,
  input wire outWordClock,
  input wire out_frame_clock,
  output reg outData,
  // control pins
  input wire in_bit_edge_select,
  input wire out_bit_edge_select,
  input wire in_format_sel_lo,
  input wire in_format_sel_hi,
  input wire out_format_sel_lo,
  input wire out_format_sel_hi,
  input wire sleep_request,
  input wire settle_speed_select,
  // status
  output reg muteOut,
  output reg overflow
);
  // RQ24: synchronise pins
  wire [13:0] pins;
  asp_sync #(.WIDTH(14)) uSync (
    .sysClk(sys_clk),
    .resetN(reset_n),
    .asyncIn({inBitClock, inWordClock, in_frame_clock, inData,
      outBitClock, outWordClock, out_frame_clock,
      in_bit_edge_select, out_bit_edge_select,
      in_format_sel_hi, in_format_sel_lo,
      out_format_sel_hi, out_format_sel_lo, sleep_request}),
    .syncOut(pins)
  );
  wire iBck = pins[13];
  wire iWck = pins[12];
  wire iFrm = pins[11];
  wire iDat = pins[10];
  wire oBck = pins[9];
  wire oWck = pins[8];
  wire oFrm = pins[7];
  wire iPol = pins[6];
  wire oPol = pins[5];
  wire [1:0] iMode = {pins[3], pins[4]};
  wire [1:0] oMode = {pins[1], pins[2]};
  wire sleep = pins[0];
  // settle pin is as asynchronous as the rest, so it gets its own two flops
  wire slowSel;
  asp_sync #(.WIDTH(1)) uSyncSlow (
    .sysClk(sys_clk),
    .resetN(reset_n),
    .asyncIn(settle_speed_select),
    .syncOut(slowSel)
  );

  reg iBckD, oBckD, oFrmD, iWckS, oWckD;
  reg iFrmS, iFrmSD;
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      iBckD <= 1'b0;
      oBckD <= 1'b0;
      oFrmD <= 1'b0;
      oWckD <= 1'b0;
    end
    else
    begin
      iBckD <= iBck;
      oBckD <= oBck;
      oFrmD <= oFrm;
      oWckD <= oWck;
    end
  end
  // RQ7: polarity picks edge
  wire iCapEdge = iPol ? (iBckD & ~iBck) : (~iBckD & iBck);
  wire oCapEdge = oPol ? (oBckD & ~oBck) : (~oBckD & oBck);
  // output changes on the opposite edge so the sink reads it stable
  wire oShiftEdge = oPol ? (~oBckD & oBck) : (oBckD & ~oBck);

  // RQ3: frame and word clocks sampled on bit clock
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      iFrmS <= 1'b0;
      iFrmSD <= 1'b0;
      iWckS <= 1'b0;
    end
    else if (iCapEdge && !sleep)
    begin
      iFrmS <= iFrm;
      iFrmSD <= iFrmS;
      iWckS <= iWck;
    end
  end

  // input deserialiser, idle level of bit clock is irrelevant
  // RQ14: edges only, any idle
  reg [4:0] iCnt;
  reg [15:0] iShift;
  reg [31:0] iFrame;
  reg iActive, iWckD, iPairValid;
  reg [4:0] iSkip;
  wire iFrmEdge = iCapEdge && (iFrm != iFrmS);
  wire iWordRise = iCapEdge && iWck && !iWckS;
  // RQ8: mode decode
  // RQ13: word clock only in word mode
  wire iStart = (iMode == `ASP_MODE_WORD) ? iWordRise :
    (iMode == `ASP_MODE_LJ) ? iFrmEdge : 1'b0;
  wire [4:0] iDelay = (iMode == `ASP_MODE_LJ_DLY) ? 5'h01 :
    (iMode == `ASP_MODE_RJ) ? 5'h10 : 5'h00;
  // a channel closes at the next start, or at a framing edge in the delayed modes; short words pad LSBs
  wire iClose = iActive && (iStart || (iFrmEdge && iDelay != 5'h00));
  wire [15:0] iJust = iShift << (5'h10 - iCnt);
  always @(posedge sys_clk)
  begin
    if (!reset_n || sleep)
    begin
      iCnt <= 5'h00;
      iShift <= 16'h0000;
      iFrame <= 32'h00000000;
      iActive <= 1'b0;
      iSkip <= 5'h00;
      iPairValid <= 1'b0;
      iWckD <= 1'b0;
    end
    else
    begin
      iPairValid <= 1'b0;
      // RQ10: MSB on frame edge
      // RQ15: back to back channels
      // RQ5: left in high half, pair pushed when right closes
      if (iClose)
      begin
        iFrame <= iFrmS ? {iJust, iFrame[15:0]} : {iFrame[31:16], iJust};
        iPairValid <= !iFrmS;
      end
      if (iStart)
      begin
        // RQ4: MSB first
        iShift <= {15'h0000, iDat};
        iCnt <= 5'h01;
        iActive <= 1'b1;
      end
      // RQ11: one bit delay
      // RQ12: sixteen bit delay
      else if (iFrmEdge && iDelay != 5'h00)
      begin
        iSkip <= iDelay - 5'h01;
        iActive <= 1'b0;
        iCnt <= (iDelay == 5'h01) ? 5'h1F : 5'h00;
      end
      else if (iCapEdge)
      begin
        if (!iActive && iSkip != 5'h00)
          iSkip <= iSkip - 5'h01;
        else if (!iActive && (iCnt == 5'h1F || iSkip == 5'h00))
        begin
          iShift <= {15'h0000, iDat};
          iCnt <= 5'h01;
          iActive <= 1'b1;
        end
        // RQ6: at most 16 bits
        else if (iActive && iCnt < `ASP_IN_MAX_BITS)
        begin
          iShift <= {iShift[14:0], iDat};
          iCnt <= iCnt + 5'h01;
        end
      end
    end
  end

  // buffer between input and output sides
  wire bufInReady, bufOutValid;
  wire [31:0] bufOutData;
  wire bufPop;
  asp_buf2 #(.WIDTH(32), .DEPTH(2)) uBuf (
    .sysClk(sys_clk),
    .resetN(reset_n),
    .inValid(iPairValid),
    .inReady(bufInReady),
    .inData(iFrame),
    .outValid(bufOutValid),
    .outReady(bufPop),
    .outData(bufOutData)
  );
  // RQ23: crossing pointers
  wire crossWr = iPairValid && !bufInReady;
  wire crossRd = bufPop && !bufOutValid;

  // output serialiser: sample taken at left frame edge
  reg [31:0] oHold;
  reg [23:0] oShift;
  reg [4:0] oCnt;
  reg [4:0] oSkip;
  wire oFrmRise = oFrm && !oFrmD;
  wire oFrmEdge = oFrm != oFrmD;
  wire oWordRise = oWck && !oWckD;
  assign bufPop = oFrmRise && !sleep;
  wire [4:0] oDelay = (oMode == `ASP_MODE_LJ_DLY) ? 5'h01 :
    (oMode == `ASP_MODE_RJ) ? 5'h10 : 5'h00;
  // the pair popped this cycle is not in oHold yet, so bypass it
  wire [31:0] oPair = bufPop ? (bufOutValid ? bufOutData : 32'h00000000) :
    oHold;
  wire [23:0] oWord = oFrm ? {oPair[31:16], 8'h00} : {oPair[15:0], 8'h00};
  always @(posedge sys_clk)
  begin
    if (!reset_n || sleep)
    begin
      oHold <= 32'h00000000;
      oShift <= 24'h000000;
      oCnt <= 5'h00;
      oSkip <= 5'h00;
      outData <= 1'b0;
    end
    else
    begin
      if (bufPop)
        oHold <= bufOutValid ? bufOutData : 32'h00000000;
      // RQ9: word rise loads MSB
      if ((oMode == `ASP_MODE_WORD) ? oWordRise :
        (oFrmEdge && oDelay == 5'h00))
      begin
        outData <= muteOut ? 1'b0 : oWord[23];
        oShift <= {oWord[22:0], 1'b0};
        oCnt <= 5'h01;
      end
      else if (oFrmEdge)
      begin
        oSkip <= oDelay;
        oShift <= oWord;
        outData <= 1'b0;
      end
      else if (oShiftEdge)
      begin
        if (oSkip != 5'h00)
        begin
          oSkip <= oSkip - 5'h01;
          if (oSkip == 5'h01)
          begin
            outData <= muteOut ? 1'b0 : oShift[23];
            oShift <= {oShift[22:0], 1'b0};
          end
        end
        else
        begin
          // RQ6: zero past width
          outData <= muteOut ? 1'b0 : oShift[23];
          oShift <= {oShift[22:0], 1'b0};
        end
      end
    end
  end

  // rate servo: count system cycles per input and output frame
  reg [19:0] iPer, oPer, iRun, oRun;
  reg [31:0] settleCnt;
  reg [7:0] muteCnt;
  wire iFrmRise = iCapEdge && iFrm && !iFrmS;
  wire [19:0] perDiff = (iPer > oPer) ? iPer - oPer : oPer - iPer;
  // RQ19: 1:1 ratio, no flush
  // RQ20: mute while settling; here only the first 256 cycles of the window, and only while periods differ
  // RQ22: settling window
  always @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      iPer <= 20'h00000;
      oPer <= 20'h00000;
      iRun <= 20'h00000;
      oRun <= 20'h00000;
      settleCnt <= 32'h00000000;
      muteCnt <= 8'h00;
      muteOut <= 1'b1;
      overflow <= 1'b0;
    end
    // RQ17: sleep halts
    else if (sleep)
    begin
      muteOut <= 1'b1;
    end
    else
    begin
      iRun <= iFrmRise ? 20'h00000 : iRun + 20'h00001;
      oRun <= oFrmRise ? 20'h00000 : oRun + 20'h00001;
      if (iFrmRise)
        iPer <= iRun;
      if (oFrmRise)
        oPer <= oRun;
      if (muteCnt < MUTE_MIN[7:0])
        muteCnt <= muteCnt + 8'h01;
      // input and output periods differing by over half the input period restart the settle window
      if ((iFrmRise || oFrmRise) && perDiff > (iPer >> 1))
        settleCnt <= 32'h00000000;
      else if (settleCnt < (slowSel ? SLOW_SETTLE : FAST_SETTLE))
        settleCnt <= settleCnt + 32'h00000001;
      overflow <= crossWr || crossRd;
      muteOut <= (muteCnt < MUTE_MIN[7:0]) || crossWr || crossRd ||
        (settleCnt < (slowSel ? SLOW_SETTLE : FAST_SETTLE) &&
        perDiff > 20'h00000 && muteCnt >= MUTE_MIN[7:0] &&
        settleCnt < 32'h00000100);
    end
  end
endmodule

/* File: tb/asp_ports_checker.sv */
// asp_ports_checker.sv: timing checks on the serial port block
// assumes: bound to asp_ports, one sys_clk domain
`timescale 1ns/1ps
module asp_ports_checker #(
  parameter MUTE_MIN = 128
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // watched pins
  input wire outBitClock,
  input wire outWordClock,
  input wire out_frame_clock,
  input wire outData,
  input wire sleep_request,
  input wire muteOut,
  input wire overflow
);
  reg [7:0] upCnt;
  reg [3:0] evCnt;
  reg [3:0] pinQ;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // cycles since release, saturating so it never wraps
  always @(posedge sys_clk)
  begin
    if (!reset_n)
      upCnt <= 8'h00;
    else if (upCnt != 8'hFF)
      upCnt <= upCnt + 8'h01;
  end
  // cycles since an output clock or mute change
  always @(posedge sys_clk)
  begin
    pinQ <= {outBitClock, out_frame_clock, outWordClock, muteOut};
    if (!reset_n)
      evCnt <= 4'h0;
    else if (pinQ != {outBitClock, out_frame_clock, outWordClock, muteOut})
      evCnt <= 4'h0;
    else if (evCnt != 4'hF)
      evCnt <= evCnt + 4'h1;
  end
  reset_mute_a: assert property ($rose(reset_n) |-> muteOut)
    else $error("mute low at reset release");
  reset_quiet_a: assert property ($rose(reset_n) |-> !outData && !overflow)
    else $error("outputs busy at reset release");
  mute_hold_a: assert property (upCnt < MUTE_MIN |-> muteOut)
    else $error("mute released too early");
  sleep_mute_a: assert property (sleep_request [*6] |-> muteOut)
    else $error("mute low while asleep");
  sleep_still_a: assert property (sleep_request [*6] |=> $stable(outData))
    else $error("output moved while asleep");
  muted_zero_a: assert property (muteOut [*3] |-> !outData)
    else $error("output not silent under mute");
  ovf_mute_a: assert property (overflow |-> ##[0:2] muteOut)
    else $error("buffer cross without mute");
  data_timing_a: assert property ($changed(outData) |-> evCnt <= 4'h8)
    else $error("output changed with no clock edge");
  cover property ($fell(muteOut));
  cover property (overflow);
  cover property ($rose(outData));
  cover property (sleep_request [*6]);
endmodule
bind asp_ports asp_ports_checker #(.MUTE_MIN(MUTE_MIN)) chk (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .outBitClock(outBitClock),
  .outWordClock(outWordClock),
  .out_frame_clock(out_frame_clock),
  .outData(outData),
  .sleep_request(sleep_request),
  .muteOut(muteOut),
  .overflow(overflow)
);

/* File: tb/asp_serial_model.sv */
// asp_serial_model.sv: audio source and sink on the two serial ports
// assumes: both ports in lockstep, 160 ns bit clock, 32 slots a channel
`timescale 1ns/1ps
`include "asp_defines.vh"
module asp_serial_model (
  // configuration
  input wire [1:0] inMode,
  input wire [1:0] outMode,
  input wire inPol,
  input wire outPol,
  input wire stall,
  // pair to send
  input wire [15:0] txLeft,
  input wire [15:0] txRight,
  // port pins
  output reg inBitClock,
  output reg inWordClock,
  output reg in_frame_clock,
  output reg inData,
  output reg outBitClock,
  output reg outWordClock,
  output reg out_frame_clock,
  input wire outData,
  // pair read back
  output reg [23:0] rxLeft,
  output reg [23:0] rxRight,
  output reg [15:0] frames
);
  reg [15:0] word;
  reg [23:0] rx;
  integer ch, s, di, dout;
  // MSB offset of each framing code
  function integer lead(input [1:0] m);
    lead = m == `ASP_MODE_RJ ? `ASP_RJ_DELAY : m == `ASP_MODE_LJ_DLY;
  endfunction
  // frame clocks run without gaps unless told to stall
  initial
  begin
    {inBitClock, inWordClock, in_frame_clock, inData} = 4'h0;
    {outBitClock, outWordClock, out_frame_clock} = 3'h0;
    {rxLeft, rxRight, frames} = 64'h0;
    #7;
    forever
    begin
      for (ch = 0; ch < 2; ch = ch + 1)
      begin
        word = ch == 0 ? txLeft : txRight;
        di = lead(inMode);
        dout = lead(outMode);
        rx = 24'h000000;
        // left word while frame clock high
        in_frame_clock = ch == 0;
        if (!stall)
          out_frame_clock = ch == 0;
        for (s = 0; s < 32; s = s + 1)
        begin
          // launch edge; word clock only for MSB
          inBitClock = inPol;
          inWordClock = inMode == `ASP_MODE_WORD && s == 0;
          // MSB first; outside the word the line keeps toggling
          if (s >= di && s < di + 16)
            inData = word[15 - (s - di)];
          else
            inData = ~inData;
          if (!stall)
          begin
            outBitClock = outPol;
            outWordClock = outMode == `ASP_MODE_WORD && s == 0;
          end
          #80;
          inBitClock = !inPol;
          if (!stall)
            outBitClock = !outPol;
          // sample late in the bit to ride out synchroniser lag
          #60;
          if (s >= dout && s < dout + 24)
            rx[23 - (s - dout)] = outData;
          #20;
        end
        if (ch == 0)
          rxLeft = rx;
        else
          rxRight = rx;
        // bit clock idles at its last level
        #320;
      end
      frames = frames + 16'h1;
    end
  end
endmodule

/* File: tb/asp_ports_tb.sv */
// asp_ports_tb.sv: random and corner tests of the serial port block
// assumes: asp_serial_model drives both ports, checker bound to block
`timescale 1ns/1ps
module asp_ports_tb;
  reg sys_clk, reset_n, inPol, outPol, stall, sleepReq, settleSlow;
  reg ovfSeen, muteOvf;
  reg [1:0] inMode, outMode;
  reg [15:0] txLeft, txRight;
  wire inBit, inWord, inFrame, inData, outBit, outWord, outFrame;
  wire outData, muteOut, overflow;
  wire [23:0] rxLeft, rxRight;
  wire [15:0] frames;
  integer err_count, checked, cycles, i;
  // short settle windows keep the run brief
  asp_ports #(.FAST_SETTLE(1000), .SLOW_SETTLE(4000)) uut (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .inBitClock(inBit), .inWordClock(inWord),
    .in_frame_clock(inFrame), .inData(inData),
    .outBitClock(outBit), .outWordClock(outWord),
    .out_frame_clock(outFrame), .outData(outData),
    .in_bit_edge_select(inPol), .out_bit_edge_select(outPol),
    .in_format_sel_lo(inMode[1]), .in_format_sel_hi(inMode[0]),
    .out_format_sel_lo(outMode[1]), .out_format_sel_hi(outMode[0]),
    .sleep_request(sleepReq), .settle_speed_select(settleSlow),
    .muteOut(muteOut), .overflow(overflow));
  asp_serial_model sp (
    .inMode(inMode), .outMode(outMode), .inPol(inPol),
    .outPol(outPol), .stall(stall), .txLeft(txLeft),
    .txRight(txRight), .inBitClock(inBit), .inWordClock(inWord),
    .in_frame_clock(inFrame), .inData(inData),
    .outBitClock(outBit), .outWordClock(outWord),
    .out_frame_clock(outFrame), .outData(outData),
    .rxLeft(rxLeft), .rxRight(rxRight), .frames(frames));
  // 50 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // hang guard and sticky overflow watch
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (overflow === 1'b1)
    begin
      ovfSeen = 1'b1;
      muteOvf = muteOut;
    end
    if (cycles == 95000)
    begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  task check(input logic [23:0] seen, input logic [23:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // expected output word: input sample with zero low bits
  function [23:0] pad(input [15:0] w);
    pad = {w, 8'h00};
  endfunction
  task frames_pass(input integer n);
    integer f;
  begin
    f = frames + n;
    while (frames < f)
      @(posedge sys_clk);
  end
  endtask
  task restart;
    integer n;
  begin
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(muteOut, 24'h1);
    n = 0;
    while (muteOut !== 1'b0 && n < 20000)
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    check(muteOut, 24'h0);
    // first frames after release hold no pair yet
    frames_pass(3);
    ovfSeen = 1'b0;
  end
  endtask
  initial
  begin
    {reset_n, inPol, outPol, stall, sleepReq, settleSlow} = 6'h00;
    {inMode, outMode, txLeft, txRight, ovfSeen, muteOvf} = 38'h0;
    {err_count, checked, cycles} = 0;
    i = $urandom(21);
    // every framing code and polarity on both ports
    for (i = 0; i < 4; i = i + 1)
    begin
      // control pins settle before reset and data
      @(posedge sys_clk);
      inMode <= i;
      outMode <= 3 - i;
      inPol <= i % 2;
      outPol <= i / 2;
      settleSlow <= $urandom;
      txLeft <= i == 0 ? 16'h8000 : $urandom;
      txRight <= i == 0 ? 16'h7FFF : $urandom;
      restart;
      frames_pass(6);
      check(rxLeft, pad(txLeft));
      check(rxRight, pad(txRight));
      check(ovfSeen, 24'h0);
    end
    // sink stalls: buffer fills and refuses
    @(posedge sys_clk);
    stall <= 1'b1;
    frames_pass(4);
    check(ovfSeen, 24'h1);
    check(muteOvf, 24'h1);
    @(posedge sys_clk);
    stall <= 1'b0;
    restart;
    @(posedge sys_clk);
    sleepReq <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(muteOut, 24'h1);
    frames_pass(2);
    check(rxLeft, 24'h0);
    give_verdict;
  end
endmodule
